// *** hw/bank_fsm.sv ***
// Per-bank transitional state tracker with illegal command detection
`timescale 1ns/1ps
`default_nettype none
module bank_fsm
  import bank_fsm_pkg::*;
(
  input  wire logic           clk_sys,
  input  wire logic           rst_n,
  input  wire cmd_pins_s      pins,
  output logic [4*8-1:0]      bank_state,
  output logic [NUM_BANKS-1:0] illegal_bank,
  output logic                illegal_cmd,
  output logic                self_renew
);

  cmd_dec_s dec;

  cmd_decode u_dec (
    .pins (pins),
    .dec  (dec)
  );

  // Command classes shared by every bank
  logic is_quiet;
  logic is_column;
  logic is_close;

  assign is_quiet  = dec.cmd == CMD_DESELECT || dec.cmd == CMD_NOP;
  assign is_column = dec.cmd == CMD_FETCH || dec.cmd == CMD_STORE;
  assign is_close  = dec.cmd == CMD_CLOSE || dec.cmd == CMD_CLOSE_ALL;

  wire  [NUM_BANKS-1:0] ill_d;
  logic                 dev_ill_d;

  bank_state_e          st_q  [NUM_BANKS];
  logic [CNT_W-1:0]     cnt_q [NUM_BANKS];
  logic                 any_busy;
  logic                 all_idle;

  always_comb begin
    any_busy = 1'b0;
    all_idle = 1'b1;
    for (int i = 0; i < NUM_BANKS; i++) begin
      if (st_q[i] == ST_RENEW || st_q[i] == ST_MODE) begin
        any_busy = 1'b1;
      end
      if (st_q[i] != ST_IDLE) begin
        all_idle = 1'b0;
      end
    end
  end

  // Device-wide commands outside idle are illegal
  always_comb begin
    dev_ill_d = 1'b0;
    if (!dec.valid_cmd) begin
      dev_ill_d = 1'b1;
    end else if (dec.cmd == CMD_RENEW || dec.cmd == CMD_SELF_RENEW || dec.cmd == CMD_MODE_WRITE) begin
      dev_ill_d = !all_idle;
    end else if (any_busy && !is_quiet) begin
      dev_ill_d = 1'b1;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_BANKS; g++) begin : g_bank
      logic             hit;
      logic             held;
      logic             done;
      logic             ill;
      logic [CNT_W-1:0] cnt_dn;
      assign hit      = (dec.bank == BANK_W'(g)) || dec.cmd == CMD_CLOSE_ALL;
      assign held     = dev_ill_d || ill;
      assign done     = cnt_q[g] <= CNT_W'(1);
      assign cnt_dn   = done ? cnt_q[g] : cnt_q[g] - CNT_W'(1);
      assign ill_d[g] = ill;

      // Commands refused in each state of this bank
      always_comb begin
        ill = 1'b0;
        if (hit && dec.valid_cmd && !any_busy) begin
          unique case (st_q[g])
            ST_IDLE: begin
              ill = is_column;
            end
            ST_ACTIVE: begin
              ill = dec.cmd == CMD_ROW_OPEN;
            end
            ST_CLOSING: begin
              ill = is_column || dec.cmd == CMD_ROW_OPEN;
            end
            ST_OPENING: begin
              ill = is_column || is_close || dec.cmd == CMD_ROW_OPEN;
            end
            ST_WR_REC: begin
              ill = dec.cmd == CMD_FETCH || is_close || dec.cmd == CMD_ROW_OPEN;
            end
            ST_WR_REC_AC: begin
              ill = is_column || is_close || dec.cmd == CMD_ROW_OPEN;
            end
            default: begin
              ill = 1'b0;
            end
          endcase
        end
      end

      // State of this bank, frozen by a refused command
      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          st_q[g] <= ST_IDLE;
        end else if (!held) begin
          unique case (st_q[g])
            ST_IDLE: begin
              if (hit && dec.cmd == CMD_ROW_OPEN) begin
                st_q[g] <= ST_OPENING;
              end else if (dec.cmd == CMD_RENEW) begin
                st_q[g] <= ST_RENEW;
              end else if (dec.cmd == CMD_MODE_WRITE) begin
                st_q[g] <= ST_MODE;
              end
            end
            ST_ACTIVE: begin
              if (hit && is_close) begin
                st_q[g] <= ST_CLOSING;
              end else if (hit && dec.cmd == CMD_STORE) begin
                st_q[g] <= dec.auto_close_flag ? ST_WR_REC_AC : ST_WR_REC;
              end
            end
            ST_CLOSING: begin
              if (done) begin
                st_q[g] <= ST_IDLE;
              end
            end
            ST_OPENING: begin
              if (done) begin
                st_q[g] <= ST_ACTIVE;
              end
            end
            ST_WR_REC: begin
              if (hit && dec.cmd == CMD_STORE) begin
                st_q[g] <= dec.auto_close_flag ? ST_WR_REC_AC : ST_WR_REC;
              end else if (done) begin
                st_q[g] <= ST_ACTIVE;
              end
            end
            ST_WR_REC_AC: begin
              if (done) begin
                st_q[g] <= ST_CLOSING;
              end
            end
            ST_RENEW, ST_MODE: begin
              if (done) begin
                st_q[g] <= ST_IDLE;
              end
            end
            default: begin
              st_q[g] <= ST_IDLE;
            end
          endcase
        end
      end

      // Interval timer of this bank, runs on across refused commands
      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          cnt_q[g] <= '0;
        end else if (held) begin
          cnt_q[g] <= cnt_dn;
        end else if (st_q[g] == ST_IDLE && hit && dec.cmd == CMD_ROW_OPEN) begin
          cnt_q[g] <= ROW_TO_COL_CYC;
        end else if (st_q[g] == ST_IDLE && dec.cmd == CMD_RENEW) begin
          cnt_q[g] <= RENEW_CYC;
        end else if (st_q[g] == ST_IDLE && dec.cmd == CMD_MODE_WRITE) begin
          cnt_q[g] <= MODE_SETTLE_CYC;
        end else if (st_q[g] == ST_ACTIVE && hit && is_close) begin
          cnt_q[g] <= ROW_CLOSE_CYC;
        end else if ((st_q[g] == ST_ACTIVE || st_q[g] == ST_WR_REC) && hit && dec.cmd == CMD_STORE) begin
          cnt_q[g] <= WRITE_REC_CYC;
        end else if (st_q[g] == ST_WR_REC_AC && done) begin
          cnt_q[g] <= ROW_CLOSE_CYC;
        end else begin
          cnt_q[g] <= cnt_dn;
        end
      end
    end
  endgenerate

  // Registered outputs
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bank_state   <= {NUM_BANKS{ST_IDLE}};
      illegal_bank <= '0;
      illegal_cmd  <= 1'b0;
      self_renew   <= 1'b0;
    end else begin
      for (int i = 0; i < NUM_BANKS; i++) begin
        bank_state[i*8 +: 8] <= st_q[i];
      end
      illegal_bank <= ill_d | {NUM_BANKS{dev_ill_d}};
      illegal_cmd  <= dev_ill_d | (|ill_d);
      self_renew   <= (dec.cmd == CMD_SELF_RENEW) & all_idle;
    end
  end

endmodule : bank_fsm
`default_nettype wire

// *** hw/bank_fsm_pkg.sv ***
// Package: command codes, states, timing constants for the bank state tracker
package bank_fsm_pkg;

  localparam int unsigned CLK_PERIOD_PS = 10000;
  localparam int unsigned NUM_BANKS     = 4;
  localparam int unsigned BANK_W        = 2;
  localparam int unsigned ROW_W         = 14;
  localparam int unsigned COL_W         = 10;
  localparam int unsigned CNT_W         = 8;
  localparam int unsigned AUTO_CLOSE_BIT = 10;

  // Times in picoseconds
  localparam int unsigned ROW_CLOSE_TIME_PS         = 15000;
  localparam int unsigned ROW_TO_COLUMN_DELAY_PS    = 15000;
  localparam int unsigned WRITE_RECOVERY_TIME_PS    = 15000;
  localparam int unsigned RENEW_CYCLE_TIME_PS       = 105000;
  localparam int unsigned MODE_WRITE_SETTLE_TIME_PS = 20000;

  // Least times round up
  localparam logic [CNT_W-1:0] ROW_CLOSE_CYC =
    CNT_W'((ROW_CLOSE_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [CNT_W-1:0] ROW_TO_COL_CYC =
    CNT_W'((ROW_TO_COLUMN_DELAY_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [CNT_W-1:0] WRITE_REC_CYC =
    CNT_W'((WRITE_RECOVERY_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [CNT_W-1:0] RENEW_CYC =
    CNT_W'((RENEW_CYCLE_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [CNT_W-1:0] MODE_SETTLE_CYC =
    CNT_W'((MODE_WRITE_SETTLE_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

  typedef enum logic [3:0] {
    CMD_DESELECT  = 4'h0,
    CMD_NOP       = 4'h1,
    CMD_FETCH     = 4'h2,
    CMD_STORE     = 4'h3,
    CMD_ROW_OPEN  = 4'h4,
    CMD_CLOSE     = 4'h5,
    CMD_CLOSE_ALL = 4'h6,
    CMD_RENEW     = 4'h7,
    CMD_SELF_RENEW = 4'h8,
    CMD_MODE_WRITE = 4'h9
  } cmd_e;

  typedef enum logic [7:0] {
    ST_IDLE       = 8'h01,
    ST_CLOSING    = 8'h02,
    ST_OPENING    = 8'h04,
    ST_ACTIVE     = 8'h08,
    ST_WR_REC     = 8'h10,
    ST_WR_REC_AC  = 8'h20,
    ST_RENEW      = 8'h40,
    ST_MODE       = 8'h80
  } bank_state_e;

  typedef struct packed {
    logic              cs_n;
    logic              ras_n;
    logic              cas_n;
    logic              we_n;
    logic              cke;
    logic [BANK_W-1:0] bank;
    logic [ROW_W-1:0]  addr;
  } cmd_pins_s;

  typedef struct packed {
    cmd_e              cmd;
    logic [BANK_W-1:0] bank;
    logic              auto_close_flag;
    logic              valid_cmd;
  } cmd_dec_s;

endpackage : bank_fsm_pkg

// *** hw/cmd_decode.sv ***
// Command decoder from chip select, row, column and write strobes
`timescale 1ns/1ps
`default_nettype none
module cmd_decode
  import bank_fsm_pkg::*;
(
  input  wire cmd_pins_s pins,
  output var cmd_dec_s   dec
);

  always_comb begin
    dec.bank            = pins.bank;
    dec.auto_close_flag = pins.addr[AUTO_CLOSE_BIT];
    dec.valid_cmd       = 1'b1;
    if (pins.cs_n) begin
      dec.cmd = CMD_DESELECT;
    end else begin
      unique case ({pins.ras_n, pins.cas_n, pins.we_n})
        3'b111:  dec.cmd = CMD_NOP;
        3'b101:  dec.cmd = CMD_FETCH;
        3'b100:  dec.cmd = CMD_STORE;
        3'b011:  dec.cmd = CMD_ROW_OPEN;
        3'b010:  dec.cmd = pins.addr[AUTO_CLOSE_BIT] ? CMD_CLOSE_ALL : CMD_CLOSE;
        3'b001:  dec.cmd = pins.cke ? CMD_RENEW : CMD_SELF_RENEW;
        3'b000:  dec.cmd = CMD_MODE_WRITE;
        default: begin
          dec.cmd       = CMD_NOP;
          dec.valid_cmd = 1'b0;
        end
      endcase
    end
  end

endmodule : cmd_decode
`default_nettype wire

// *** verification/bank_fsm_monitor.sv ***
// Checker for bank state timing and command legality
`timescale 1ns/1ps
`default_nettype none
module bank_fsm_monitor
  import bank_fsm_pkg::*;
(
  input wire logic                 clk_sys,
  input wire logic                 rst_n,
  input wire cmd_pins_s            pins,
  input wire logic [4*8-1:0]       bank_state,
  input wire logic [NUM_BANKS-1:0] illegal_bank,
  input wire logic                 illegal_cmd,
  input wire logic                 self_renew
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic [CNT_W-1:0] renew_cnt_q;
  wire logic [7:0]  bs0 = bank_state[7:0];
  wire logic        sel0 = !pins.cs_n && pins.bank == 2'h0;
  // Cycles spent in renew
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      renew_cnt_q <= '0;
    end else begin
      renew_cnt_q <= bank_state[6] ? renew_cnt_q + 1'b1 : '0;
    end
  end
  AST_CLOSING_IDLE: assert property ($rose(bs0[1]) |=> bs0[1] ##1 bs0[0]) else $error("closing exit");
  AST_OPENING_ACTIVE: assert property ($rose(bs0[2]) |=> bs0[2] ##1 bs0[3]) else $error("opening exit");
  AST_WREC_AC_CLOSE: assert property ($rose(bs0[5]) |=> bs0[5] ##1 bs0[1]) else $error("recovery exit");
  AST_RENEW_SPAN: assert property ($fell(bank_state[6]) |-> renew_cnt_q == RENEW_CYC) else $error("renew span");
  AST_MODE_IDLE: assert property ($rose(bs0[7]) |=> bs0[7] ##1 bs0[0]) else $error("mode exit");
  AST_ILLEGAL_HOLD: assert property (illegal_bank[0] |=> $stable(bs0)) else $error("state moved");
  AST_FETCH_REFUSED: assert property ((sel0 && {pins.ras_n, pins.cas_n, pins.we_n} == 3'h5) ##1
    ((bs0 & 8'hf6) != 8'h00) |-> illegal_bank[0]) else $error("fetch not flagged");
  AST_CLOSE_ON_CLOSING: assert property ((sel0 && {pins.ras_n, pins.cas_n, pins.we_n} == 3'h2) ##1
    bs0[1] |-> !illegal_bank[0]) else $error("close flagged");
  AST_FLAG_OR: assert property (illegal_cmd == |illegal_bank) else $error("flag summary");
endmodule : bank_fsm_monitor
bind bank_fsm bank_fsm_monitor mon (.clk_sys(clk_sys), .rst_n(rst_n), .pins(pins), .bank_state(bank_state),
  .illegal_bank(illegal_bank), .illegal_cmd(illegal_cmd), .self_renew(self_renew));
`default_nettype wire

// *** verification/dram_ctl_model.sv ***
// Memory controller model driving command pins
`timescale 1ns/1ps
`default_nettype none
module dram_ctl_model
  import bank_fsm_pkg::*;
(
  input  wire logic clk_sys,
  output var cmd_pins_s pins
);
  logic [3:0]  s;
  logic [12:0] addr_seq = 13'h0000;
  initial pins = '1;
  // One command per cycle, set at a falling edge
  task automatic issue(input cmd_e c, input logic [1:0] b, input logic ac);
    logic a10;
    a10 = (c == CMD_CLOSE_ALL) || (c != CMD_CLOSE && ac);
    case (c)
      CMD_NOP:                  s = 4'h7;
      CMD_FETCH:                s = 4'h5;
      CMD_STORE:                s = 4'h4;
      CMD_ROW_OPEN:             s = 4'h3;
      CMD_CLOSE, CMD_CLOSE_ALL: s = 4'h2;
      CMD_RENEW, CMD_SELF_RENEW: s = 4'h1;
      CMD_MODE_WRITE:           s = 4'h0;
      default:                  s = {1'b1, ~pins.ras_n, ~pins.cas_n, ~pins.we_n};
    endcase
    pins = {s, c != CMD_SELF_RENEW, (c == CMD_DESELECT) ? {~pins.bank, ~pins.addr}
                                                        : {b, addr_seq[12:10], a10, addr_seq[9:0]}};
    addr_seq = addr_seq + 13'h0029;
    @(negedge clk_sys);
  endtask : issue
  // Quiet cycles while a bank settles
  task automatic idle(input int n);
    for (int i = 0; i < n; i++) begin
      issue(i[0] ? CMD_DESELECT : CMD_NOP, 2'h0, 1'b0);
    end
  endtask : idle
endmodule : dram_ctl_model
`default_nettype wire

// *** verification/sdram_bank_transition_rules_bench.sv ***
// Self-checking bench for the bank state tracker
`timescale 1ns/1ps
`default_nettype none
module sdram_bank_transition_rules_bench
  import bank_fsm_pkg::*;
;
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  cmd_pins_s   pins;
  logic [31:0] bank_state;
  logic [3:0]  illegal_bank;
  logic        illegal_cmd;
  logic        self_renew;
  int          err_count = 0;
  int          tests_run = 0;
  always #5 clk_sys = ~clk_sys;
  dram_ctl_model ctl (.clk_sys(clk_sys), .pins(pins));
  bank_fsm uut (.clk_sys(clk_sys), .rst_n(rst_n), .pins(pins), .bank_state(bank_state),
    .illegal_bank(illegal_bank), .illegal_cmd(illegal_cmd), .self_renew(self_renew));
  task automatic chk(input logic ok, input string m);
    tests_run++;
    if (!ok) begin
      err_count++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish
  // Open a row, refused fetch while opening
  task automatic t_open();
    ctl.issue(CMD_ROW_OPEN, 2'h0, 1'b0);
    ctl.issue(CMD_FETCH, 2'h0, 1'b0);
    chk(illegal_bank === 4'h1, "fetch to opening bank");
    ctl.idle(2);
    chk(bank_state[7:0] === ST_ACTIVE, "open not active");
  endtask : t_open
  // Store twice, then store with auto close
  task automatic t_write();
    ctl.issue(CMD_STORE, 2'h0, 1'b0);
    ctl.issue(CMD_STORE, 2'h0, 1'b0);
    chk(illegal_cmd === 1'b0, "second store refused");
    ctl.idle(2);
    chk(bank_state[7:0] === ST_WR_REC, "no restart");
    ctl.idle(1);
    chk(bank_state[7:0] === ST_ACTIVE, "recovery exit");
    ctl.issue(CMD_STORE, 2'h0, 1'b1);
    ctl.idle(3);
    chk(bank_state[7:0] === ST_CLOSING, "not closing");
    ctl.issue(CMD_CLOSE_ALL, 2'h0, 1'b1);
    chk(illegal_cmd === 1'b0, "close all refused");
    ctl.idle(1);
    chk(bank_state[7:0] === ST_IDLE, "close exit");
  endtask : t_write
  // Mode write with an intruding row open
  task automatic t_mode();
    ctl.issue(CMD_MODE_WRITE, 2'h0, 1'b0);
    ctl.issue(CMD_ROW_OPEN, 2'h0, 1'b0);
    chk(illegal_cmd === 1'b1, "open during mode");
    ctl.idle(2);
    chk(bank_state === {4{ST_IDLE}}, "mode exit");
  endtask : t_mode
  // Renew span, then self renew entry
  task automatic t_renew();
    ctl.issue(CMD_RENEW, 2'h0, 1'b0);
    chk(self_renew === 1'b0, "renew taken as self");
    ctl.idle(11);
    chk(bank_state[31:24] === ST_RENEW, "renew too short");
    ctl.idle(1);
    chk(bank_state === {4{ST_IDLE}}, "renew exit");
    ctl.issue(CMD_SELF_RENEW, 2'h0, 1'b0);
    chk(self_renew === 1'b1, "self renew missed");
  endtask : t_renew
  // Other banks while one settles, single close, refused column commands
  task automatic t_banks();
    ctl.issue(CMD_ROW_OPEN, 2'h1, 1'b0);
    ctl.issue(CMD_ROW_OPEN, 2'h2, 1'b0);
    chk(illegal_cmd === 1'b0, "open to other bank refused");
    ctl.issue(CMD_STORE, 2'h1, 1'b0);
    chk(illegal_bank === 4'h2, "store to opening bank");
    ctl.issue(CMD_NOP, 2'h0, 1'b0);
    ctl.issue(CMD_STORE, 2'h1, 1'b0);
    ctl.issue(CMD_FETCH, 2'h1, 1'b0);
    chk(illegal_bank === 4'h2, "fetch in recovery");
    ctl.issue(CMD_CLOSE, 2'h2, 1'b0);
    chk(illegal_cmd === 1'b0, "single close refused");
    ctl.idle(1);
    chk(bank_state[15:8] === ST_ACTIVE, "recovery not over");
    chk(bank_state[23:16] === ST_CLOSING, "single close lost");
    ctl.issue(CMD_RENEW, 2'h0, 1'b0);
    chk(illegal_bank === 4'hf, "renew with open rows");
    ctl.issue(CMD_CLOSE, 2'h1, 1'b0);
    ctl.idle(3);
    chk(bank_state === {4{ST_IDLE}}, "banks not idle");
  endtask : t_banks
  initial begin
    #20000;
    err_count++;
    tally_and_finish();
  end
  initial begin
    repeat (5) @(negedge clk_sys);
    rst_n = 1'b1;
    t_open();
    t_write();
    t_mode();
    t_renew();
    t_banks();
    tally_and_finish();
  end
endmodule : sdram_bank_transition_rules_bench
`default_nettype wire
